//--- logic/gdc_regs.sv
// primary configuration and runtime control registers of the gate driver
// assumes event inputs come from primary logic on the same clock
`timescale 1ns/1ps

module gdc_regs (
   input  wire logic clock,                                 // primary clock
   input  wire logic nrst,                                  // async reset, low
   input  wire logic sclk,                                  // serial clock pin
   input  wire logic cs_n,                                  // chip select pin, low
   input  wire logic mosi,                                  // serial data in pin
   input  wire logic class_a_event,                         // class a event pulse
   input  wire logic class_a_cond,                          // class a condition level
   input  wire logic class_b_event,                         // class b event pulse
   input  wire logic class_b_cond,                          // class b condition level
   input  wire logic comm_loss,                             // secondary link lost level
   output logic      miso,                                  // serial data out pin
   output logic      miso_oe,                               // high while miso driven
   output logic      fault_pin_a_n,                         // fault pin a, low = fault
   output logic      fault_pin_b_n,                         // fault pin b, low = fault
   output logic      clear_primary_req,                     // one-cycle primary clear
   output logic      clear_secondary_req,                   // one-cycle secondary clear
   output logic      watchdog_refresh_req,                  // one-cycle watchdog refresh
   output logic      blanking_time_select,                  // 0 setting 0, 1 setting 1
   output logic      spi_error_flag,                        // sticky frame error
   output logic      comm_error_flag                        // sticky link loss
);

   // ==========================================================================
   // declarations
   // ==========================================================================
   gdc_pkg::gdc_state_t q;                                  // registered state
   gdc_pkg::gdc_state_t d;                                  // next state
   gdc_pkg::gdc_rx_t    rx;                                 // frame from shifter
   logic [15:0]         tx_word;                            // readout for next frame
   logic [3:0]          rx_addr;                            // addressed register
   logic                mapped;                             // address is a register
   logic                par_ok;                             // odd parity holds
   logic                discard;                            // frame must be dropped
   logic                accepted;                           // frame taken
   logic                wr_ctrl;                            // accepted control write

   // odd parity bit over bits 15..1
   function automatic logic odd_bit(input logic [15:0] v);
      odd_bit = ~(^v[15:1]);
   endfunction

   // readout of one register with status and parity filled in
   function automatic logic [15:0] readout(input logic [3:0] a,
                                           input gdc_pkg::gdc_state_t s);
      logic [15:0] r;
      r = 16'h0000;
      if (a == gdc_pkg::ADDR_CFG) begin
         r = s.cfg & gdc_pkg::CFG_WMASK;
      end else if (a == gdc_pkg::ADDR_CTRL) begin
         r = s.ctrl & gdc_pkg::CTRL_WMASK;
      end
      r[gdc_pkg::BIT_DISCARD] = s.discarded;
      r[gdc_pkg::BIT_PARITY] = odd_bit(r);
      readout = r;
   endfunction

   // ==========================================================================
   // serial shifter
   // ==========================================================================
   gdc_spi_frame #(
      .FRAME_W (gdc_pkg::FRAME_W)
   ) u_spi (
      .clock   (clock),
      .nrst    (nrst),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .mosi    (mosi),
      .tx_word (tx_word),
      .miso    (miso),
      .miso_oe (miso_oe),
      .rx      (rx)
   );

   // ==========================================================================
   // frame decode
   // ==========================================================================
   // the readout is latched by the shifter at the next frame start
   always_comb begin
      tx_word  = readout(q.rsp_addr, q);
      rx_addr  = rx.word[gdc_pkg::FRM_ADDR_HI:gdc_pkg::FRM_ADDR_LO];
      mapped   = (rx_addr == gdc_pkg::ADDR_CFG) || (rx_addr == gdc_pkg::ADDR_CTRL);
      par_ok   = ^rx.word;
      // parity only counts when the check is enabled
      discard  = !rx.len_ok || !mapped
               || (q.cfg[gdc_pkg::CFG_PAR_EN] && !par_ok);
      accepted = rx.valid && !discard;
      wr_ctrl  = accepted && rx.word[gdc_pkg::FRM_WRITE] && (rx_addr == gdc_pkg::ADDR_CTRL);
   end

   // ==========================================================================
   // next state
   // ==========================================================================
   always_comb begin
      d = q;
      // request bits live for one cycle only
      d.ctrl[gdc_pkg::CTL_CLR_SEC]    = 1'b0;
      d.ctrl[gdc_pkg::CTL_CLR_PRI]    = 1'b0;
      d.ctrl[gdc_pkg::CTL_WD_REFRESH] = 1'b0;
      // frame end: status, readback address, masked write
      if (rx.valid) begin
         d.discarded = discard;
         if (accepted) begin
            d.rsp_addr = rx_addr;
            if (rx.word[gdc_pkg::FRM_WRITE]) begin
               if (rx_addr == gdc_pkg::ADDR_CFG) begin
                  d.cfg = rx.word & gdc_pkg::CFG_WMASK;
               end else begin
                  d.ctrl = rx.word & gdc_pkg::CTRL_WMASK;
               end
            end
         end
      end
      // primary clear acts while its request bit is high
      if (q.ctrl[gdc_pkg::CTL_CLR_PRI]) begin
         if (!q.cfg[gdc_pkg::CFG_A_MODE] || !class_a_cond) begin
            d.fault_a_n = 1'b1;
         end
         if (!q.cfg[gdc_pkg::CFG_B_MODE] || !class_b_cond) begin
            d.fault_b_n = 1'b1;
         end
         d.spi_err = 1'b0;
         if (!comm_loss) begin
            d.comm_err = 1'b0;
         end
      end
      // new events win over a clear in the same cycle
      if (class_a_event) begin
         d.fault_a_n = 1'b0;
      end
      if (class_b_event) begin
         d.fault_b_n = 1'b0;
      end
      if (rx.valid && discard) begin
         d.spi_err = 1'b1;
      end
      if (comm_loss) begin
         d.comm_err = 1'b1;
      end
   end

   // ==========================================================================
   // state register
   // ==========================================================================
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         q           <= '0;
         q.cfg       <= gdc_pkg::CFG_RESET;
         q.ctrl      <= gdc_pkg::CTRL_RESET;
         q.rsp_addr  <= gdc_pkg::ADDR_CFG;
         q.fault_a_n <= 1'b1;
         q.fault_b_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state flops
   assign fault_pin_a_n        = q.fault_a_n;
   assign fault_pin_b_n        = q.fault_b_n;
   assign clear_primary_req    = q.ctrl[gdc_pkg::CTL_CLR_PRI];
   assign clear_secondary_req  = q.ctrl[gdc_pkg::CTL_CLR_SEC];
   assign watchdog_refresh_req = q.ctrl[gdc_pkg::CTL_WD_REFRESH];
   assign blanking_time_select = q.ctrl[gdc_pkg::CTL_BLANK_SEL];
   assign spi_error_flag       = q.spi_err;
   assign comm_error_flag      = q.comm_err;

   // ==========================================================================
   // assertions
   // ==========================================================================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_req_pulse(sig);
      sig ##1 !sig;
   endsequence

   a_discard_tracks_frame: assert property (rx.valid |=> q.discarded == $past(discard))
      else $error("discard status not shown");
   a_clr_sec_pulse: assert property (
      (wr_ctrl && rx.word[gdc_pkg::CTL_CLR_SEC]) |=> s_req_pulse(clear_secondary_req))
      else $error("secondary clear not a single pulse");
   a_clr_pri_pulse: assert property (
      (wr_ctrl && rx.word[gdc_pkg::CTL_CLR_PRI]) |=> s_req_pulse(clear_primary_req))
      else $error("primary clear not a single pulse");
   a_wd_refresh_pulse: assert property (
      (wr_ctrl && rx.word[gdc_pkg::CTL_WD_REFRESH]) |=> s_req_pulse(watchdog_refresh_req))
      else $error("watchdog refresh not a single pulse");
   a_blank_sel_write: assert property (
      wr_ctrl |=> blanking_time_select == $past(rx.word[gdc_pkg::CTL_BLANK_SEL]))
      else $error("blanking select not written");
   a_fault_a_always: assert property (
      (clear_primary_req && !q.cfg[gdc_pkg::CFG_A_MODE] && !class_a_event) |=> fault_pin_a_n)
      else $error("pin a not released in always mode");
   a_fault_b_holds: assert property (
      (clear_primary_req && q.cfg[gdc_pkg::CFG_B_MODE] && class_b_cond && !fault_pin_b_n)
      |=> !fault_pin_b_n)
      else $error("pin b released while class b present");
   a_parity_off_ok: assert property (
      (rx.valid && rx.len_ok && mapped && !q.cfg[gdc_pkg::CFG_PAR_EN]) |-> !discard)
      else $error("parity checked while disabled");
   a_comm_sticky: assert property ((comm_error_flag && comm_loss) |=> comm_error_flag)
      else $error("sticky flag dropped with condition active");
   a_readout_odd: assert property (^tx_word && tx_word[15:8] == 8'h00)
      else $error("readout parity or reserved bits wrong");

endmodule

//--- logic/gdc_pkg.sv
// shared constants, frame layout and state types of the primary config/control bank
// assumes a 50 MHz primary clock and a 16-bit mode-0 serial frame from the host
package gdc_pkg;

   // ==========================================================================
   // frame and clock
   // ==========================================================================
   localparam int unsigned CLOCK_HZ   = 50_000_000;         // primary clock rate
   localparam int unsigned FRAME_W    = 16;                 // bits per serial frame
   localparam logic [4:0]  FRAME_BITS = 5'h10;              // expected edge count
   localparam logic [4:0]  CNT_SAT    = 5'h11;              // count stops here

   // frame fields: write flag, register address, parity
   localparam int unsigned FRM_WRITE   = 15;                // 1 = write, 0 = read
   localparam int unsigned FRM_ADDR_HI = 14;                // address msb
   localparam int unsigned FRM_ADDR_LO = 11;                // address lsb

   // ==========================================================================
   // register map
   // ==========================================================================
   localparam logic [3:0]  ADDR_CFG  = 4'h4;                // primary_configuration
   localparam logic [3:0]  ADDR_CTRL = 4'h6;                // primary_runtime_control

   // bit positions common to every readout
   localparam int unsigned BIT_PARITY = 0;                  // odd parity bit
   localparam int unsigned BIT_DISCARD = 1;                 // last_frame_discarded

   // primary_configuration fields
   localparam int unsigned CFG_PAR_EN = 2;                  // rx_parity_check_enable
   localparam int unsigned CFG_A_MODE = 6;                  // fault_a_clear_mode
   localparam int unsigned CFG_B_MODE = 7;                  // fault_b_clear_mode

   // primary_runtime_control fields
   localparam int unsigned CTL_BLANK_SEL  = 2;              // blanking_time_select
   localparam int unsigned CTL_WD_REFRESH = 3;              // blanking_watchdog_refresh
   localparam int unsigned CTL_CLR_PRI    = 5;              // clear_primary_sticky
   localparam int unsigned CTL_CLR_SEC    = 6;              // clear_secondary_sticky

   // reset values and writable masks
   localparam logic [15:0] CFG_RESET  = 16'h00c4;           // modes and parity check on
   localparam logic [15:0] CTRL_RESET = 16'h0001;           // parity only
   localparam logic [15:0] CFG_WMASK  = 16'h00c4;           // writable config bits
   localparam logic [15:0] CTRL_WMASK = 16'h006c;           // writable control bits

   // ==========================================================================
   // types
   // ==========================================================================
   typedef enum logic [1:0] {
      GDC_IDLE  = 2'b01,                                    // chip select high
      GDC_SHIFT = 2'b10                                     // frame in progress
   } gdc_spi_st_t;

   // received frame handed to the register bank
   typedef struct packed {
      logic [15:0] word;                                    // received bits, msb first
      logic        len_ok;                                  // exactly sixteen clocks
      logic        valid;                                   // one-cycle frame end
   } gdc_rx_t;

   // serial shifter state
   typedef struct packed {
      gdc_spi_st_t st;                                      // shifter state
      logic        sclk_s1;                                 // sclk sync stage 1
      logic        sclk_s2;                                 // sclk sync stage 2
      logic        sclk_p;                                  // sclk previous
      logic        cs_s1;                                   // select sync stage 1
      logic        cs_s2;                                   // select sync stage 2
      logic        mosi_s1;                                 // data sync stage 1
      logic        mosi_s2;                                 // data sync stage 2
      logic [4:0]  cnt;                                     // sampled clock edges
      logic [15:0] rx_sh;                                   // receive shifter
      logic [15:0] tx_sh;                                   // transmit shifter
      logic        miso;                                    // data out
      logic        miso_oe;                                 // data out enable
      gdc_rx_t     rx;                                      // frame to the bank
   } gdc_spi_state_t;

   // register bank state
   typedef struct packed {
      logic [15:0] cfg;                                     // configuration bits
      logic [15:0] ctrl;                                    // control bits
      logic        discarded;                               // last frame discarded
      logic [3:0]  rsp_addr;                                // register read back next
      logic        fault_a_n;                               // pin a, low = fault
      logic        fault_b_n;                               // pin b, low = fault
      logic        spi_err;                                 // sticky frame error
      logic        comm_err;                                // sticky link loss
   } gdc_state_t;

endpackage

//--- logic/gdc_spi_frame.sv
// serial shifter: 16-bit mode-0 frames, oversampled by the primary clock
// assumes sclk well below a quarter of the clock; pins are asynchronous
`timescale 1ns/1ps

module gdc_spi_frame #(
   parameter int unsigned FRAME_W = gdc_pkg::FRAME_W        // frame length
) (
   input  wire logic           clock,                       // primary clock
   input  wire logic           nrst,                        // async reset, low
   input  wire logic           sclk,                        // serial clock pin
   input  wire logic           cs_n,                        // chip select pin, low
   input  wire logic           mosi,                        // data in pin
   input  wire logic [15:0]    tx_word,                     // readout for next frame
   output logic                miso,                        // data out pin
   output logic                miso_oe,                     // high while driving miso
   output gdc_pkg::gdc_rx_t    rx                           // received frame
);

   // ==========================================================================
   // elaboration check
   // ==========================================================================
   if (FRAME_W != 16) begin : g_bad_width
      $error("gdc_spi_frame supports only 16-bit frames");
   end

   gdc_pkg::gdc_spi_state_t q;                              // registered state
   gdc_pkg::gdc_spi_state_t d;                              // next state
   logic                    rise;                           // sampled sclk rise
   logic                    fall;                           // sampled sclk fall

   // ==========================================================================
   // next state
   // ==========================================================================
   // stage 1 of each synchroniser feeds stage 2 only
   always_comb begin
      d          = q;
      d.sclk_s1  = sclk;
      d.sclk_s2  = q.sclk_s1;
      d.sclk_p   = q.sclk_s2;
      d.cs_s1    = cs_n;
      d.cs_s2    = q.cs_s1;
      d.mosi_s1  = mosi;
      d.mosi_s2  = q.mosi_s1;
      d.rx.valid = 1'b0;
      rise       = q.sclk_s2 & ~q.sclk_p;
      fall       = ~q.sclk_s2 & q.sclk_p;
      unique case (q.st)
         gdc_pkg::GDC_IDLE: begin
            // frame start: load readout, put msb on the wire
            if (!q.cs_s2) begin
               d.st      = gdc_pkg::GDC_SHIFT;
               d.cnt     = 5'h00;
               d.tx_sh   = tx_word;
               d.miso    = tx_word[15];
               d.miso_oe = 1'b1;
            end
         end
         gdc_pkg::GDC_SHIFT: begin
            if (q.cs_s2) begin
               // frame end: hand over word and length check
               d.st        = gdc_pkg::GDC_IDLE;
               d.miso      = 1'b0;
               d.miso_oe   = 1'b0;
               d.rx.word   = q.rx_sh;
               d.rx.len_ok = (q.cnt == gdc_pkg::FRAME_BITS);
               d.rx.valid  = 1'b1;
            end else begin
               // sample on rise, saturating the edge count
               if (rise) begin
                  d.rx_sh = {q.rx_sh[14:0], q.mosi_s2};
                  if (q.cnt != gdc_pkg::CNT_SAT) begin
                     d.cnt = q.cnt + 5'h01;
                  end
               end
               // shift out on fall
               if (fall) begin
                  d.tx_sh = {q.tx_sh[14:0], 1'b0};
                  d.miso  = q.tx_sh[14];
               end
            end
         end
         // illegal state code: fall back to idle
         default: begin
            d.st = gdc_pkg::GDC_IDLE;
         end
      endcase
   end

   // ==========================================================================
   // state register
   // ==========================================================================
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         q    <= '0;
         q.st <= gdc_pkg::GDC_IDLE;
         q.cs_s1 <= 1'b1;
         q.cs_s2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign miso    = q.miso;
   assign miso_oe = q.miso_oe;
   assign rx      = q.rx;

endmodule

//--- bench/gdc_host_model.sv
// host-side serial master model that talks to the primary register bank
// assumes mode 0 frames, paced by the same primary clock as the bank
`timescale 1ns/1ps

module gdc_host_model (
   input  wire logic clock,                                 // primary clock, paces sclk
   input  wire logic miso,                                  // serial data from the bank
   output logic      sclk,                                  // serial clock, idle low
   output logic      cs_n,                                  // chip select, low in frames
   output logic      mosi                                   // serial data to the bank
);
   // =========================================================================
   // frame transfer
   // =========================================================================
   // idle levels: not selected, clock still
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // one frame msb first, sclk high and low four clocks each, readout on rise
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
         mosi <= w[i];
         repeat (4) @(posedge clock);
         sclk <= 1'b1;
         r[i] = miso;
         repeat (4) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      mosi <= ~mosi;                                        // released line must not hold a bit
      repeat (10) @(posedge clock);
   endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench of the primary configuration and control registers
// assumes the host model drives the serial pins and the bench the events
`timescale 1ns/1ps

module tb_top;
   // =========================================================================
   // signals and instances
   // =========================================================================
   logic clock, nrst, ev_a, cond_a, ev_b, cond_b, comm_loss;  // bench-driven inputs
   logic sclk, cs_n, mosi, miso, oe, pin_a, pin_b;          // link and pin outputs
   logic clr_pri, clr_sec, wd_ref, blank, spi_err, comm_err; // request and flag outputs
   logic [15:0] r;                                          // last readout
   int err_count, compares, cyc, n_p, n_s, n_w, n_o;        // counters

   gdc_host_model i_host (.clock(clock), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
   gdc_regs i_dut (.clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .class_a_event(ev_a), .class_a_cond(cond_a), .class_b_event(ev_b),
      .class_b_cond(cond_b), .comm_loss(comm_loss), .miso(miso), .miso_oe(oe),
      .fault_pin_a_n(pin_a), .fault_pin_b_n(pin_b), .clear_primary_req(clr_pri),
      .clear_secondary_req(clr_sec), .watchdog_refresh_req(wd_ref),
      .blanking_time_select(blank), .spi_error_flag(spi_err), .comm_error_flag(comm_err));

   // =========================================================================
   // helpers
   // =========================================================================
   // clock, timeout and request pulse counters
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      n_p += clr_pri;
      n_s += clr_sec;
      n_w += wd_ref;
      n_o += oe;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   // frame: write flag, address, data bits, odd parity in bit 0
   function automatic logic [15:0] mk(input logic w, input logic [3:0] a, input logic [15:0] d);
      logic [15:0] f;
      f = {w, a, 11'h000} | (d & 16'h00fc);
      f[0] = ~^f[15:1];
      return f;
   endfunction

   task automatic acc(input logic [15:0] f);
      n_o = 0;
      i_host.xfer(f, r);
      chk({15'h0, ^r}, 16'h0001, "readout parity");
      chk({14'h0, oe, n_o != 0}, 16'h0001, "miso driven in frame only");
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // =========================================================================
   // scenarios
   // =========================================================================
   task automatic t_reset();
      acc(mk(1'b0, gdc_pkg::ADDR_CTRL, 16'h0));
      chk(r, 16'h00c4, "config reset");
      acc(mk(1'b0, gdc_pkg::ADDR_CTRL, 16'h0));
      chk(r, 16'h0001, "control reset");
      $display("reset test done");
   endtask

   task automatic t_ctrl();
      n_s = 0;
      n_w = 0;
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h005c));          // reserved bit 4 also written
      chk({15'h0, blank}, 16'h0001, "blanking select");
      chk(16'(n_s), 16'h0001, "secondary clear pulse");
      chk(16'(n_w), 16'h0001, "watchdog pulse");
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0000));
      chk(r, 16'h0004, "requests self-cleared");
      chk({15'h0, blank}, 16'h0000, "blanking back");
      $display("control test done");
   endtask

   task automatic t_fault();
      n_p = 0;
      {ev_a, ev_b, cond_a, comm_loss} <= 4'hf;
      @(posedge clock);
      {ev_a, ev_b} <= 2'b00;
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0020));
      chk({14'h0, pin_a, pin_b}, 16'h0001, "mode 1 clear");
      chk({15'h0, comm_err}, 16'h0001, "sticky kept");
      {ev_b, cond_a, cond_b} <= 3'b101;
      @(posedge clock);
      ev_b <= 1'b0;
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0020));
      chk({14'h0, pin_a, pin_b}, 16'h0002, "mode 1 holds b");
      acc(mk(1'b1, gdc_pkg::ADDR_CFG, 16'h0004));
      {ev_a, cond_a, comm_loss} <= 3'b110;
      @(posedge clock);
      ev_a <= 1'b0;
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0020));
      chk({13'h0, pin_a, pin_b, comm_err}, 16'h0006, "mode 0 clear");
      chk(16'(n_p), 16'h0003, "primary clear pulses");
      $display("fault pin test done");
   endtask

   task automatic t_parity();
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0004) ^ 16'h0001);
      chk({14'h0, blank, spi_err}, 16'h0001, "bad parity refused");
      acc(mk(1'b1, gdc_pkg::ADDR_CFG, 16'h0000));
      chk({15'h0, r[1]}, 16'h0001, "discard shown");
      acc(mk(1'b1, gdc_pkg::ADDR_CTRL, 16'h0004) ^ 16'h0001);
      chk({15'h0, blank}, 16'h0001, "parity check off");
      acc(mk(1'b0, gdc_pkg::ADDR_CFG, 16'h0));
      chk(r, 16'h0004, "accepted, no discard");
      acc(mk(1'b0, 4'h5, 16'h0));
      acc(mk(1'b0, gdc_pkg::ADDR_CFG, 16'h0));
      chk(r, 16'h0002, "unmapped address discarded");
      $display("parity test done");
   endtask

   // reset for three cycles, then the scenarios in turn
   initial begin
      {nrst, ev_a, cond_a, ev_b, cond_b, comm_loss} = 6'h0;
      {err_count, compares, cyc, n_p, n_s, n_w} = '0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_ctrl();
      t_fault();
      t_parity();
      close_out();
   end
endmodule
